// ===== src/aici_pkg.sv
// constants and types shared by the serial command interface of the converter
package aici_pkg;
    // time base of the system clock
    localparam int CLK_PERIOD_NS = 40;

    // slave addressing: fixed upper bits and the general-call address
    localparam logic [2:0] ADDR_PREFIX = 3'h4;
    localparam logic [6:0] GCALL_ADDR = 7'h00;
    localparam logic [7:0] GCALL_RESET = 8'h06;

    // strap states, encoded as the two address bits each strap produces
    localparam logic [1:0] STRAP_GND = 2'h0;
    localparam logic [1:0] STRAP_VDD = 2'h1;
    localparam logic [1:0] STRAP_SDA = 2'h2;
    localparam logic [1:0] STRAP_SCL = 2'h3;

    // command byte encodings: value and mask of the bits that matter
    localparam logic [7:0] CMD_RESET_VAL = 8'h06;
    localparam logic [7:0] CMD_RESET_MASK = 8'hfe;
    localparam logic [7:0] CMD_START_VAL = 8'h08;
    localparam logic [7:0] CMD_START_MASK = 8'hfe;
    localparam logic [7:0] CMD_SLEEP_VAL = 8'h02;
    localparam logic [7:0] CMD_SLEEP_MASK = 8'hfe;
    localparam logic [7:0] CMD_FETCH_VAL = 8'h10;
    localparam logic [7:0] CMD_FETCH_MASK = 8'hf0;
    localparam logic [7:0] CMD_REGRD_VAL = 8'h20;
    localparam logic [7:0] CMD_REGRD_MASK = 8'hf8;
    localparam logic [7:0] CMD_REGWR_VAL = 8'h40;
    localparam logic [7:0] CMD_REGWR_MASK = 8'hfc;
    localparam int REGRD_SEL_BIT = 2;

    // register contents
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int CFG_CONT_BIT = 1;

    // result format limits
    localparam logic [23:0] SAT_POS = 24'h7fffff;
    localparam logic [23:0] SAT_NEG = 24'h800000;

    // timing: least times round up to whole cycles
    localparam int BUS_FREE_NS = 500;
    localparam int BUS_FREE_CYC = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READY_RELEASE_NS = 2000;
    localparam int READY_RELEASE_CYC = (READY_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MOD_PERIOD_NS = 1000;
    localparam int MOD_PERIOD_CYC = (MOD_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMEOUT_MOD_PERIODS = 14000;

    // serial engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ADDR_ACK = 3'h2,
        ST_WR = 3'h3,
        ST_WR_ACK = 3'h4,
        ST_RD = 3'h5,
        ST_RD_ACK = 3'h6,
        ST_SKIP = 3'h7
    } aici_state_e;
endpackage

// ===== src/aici_core.sv
// serial command interface: slave engine, command decoder, ready pin and result handling
// What this block does
// - ready pin low on new result, released when fetched
// - unread continuous result: release pin before newer one
// - slave up to 1 Mbps, no high-speed mode
// - start condition detected, bus marked busy
// - decode seven address bits and direction bit
// - acknowledge own or general-call address, leave high otherwise
// - bytes most significant bit first, each acknowledged
// - stop frees bus after bus-free time
// - general call write acknowledged, 06h resets device
// - idle started transaction times out, interface resets
// - result is 24-bit two's complement, MSB byte first
// - results saturate at both full-scale codes
// - reset, start, sleep commands ignore lowest bit
// - fetch, register read and write decoding
// - commands act on eighth falling clock edge
// - reset command restores defaults, bus stays usable
// - single-shot start restarts an ongoing conversion
// - continuous start begins or restarts conversions
// - sleep waits for conversion, keeps registers
// - fetch copies latest result to shift register
// - result arriving during fetch keeps pin low in single-shot mode
// - address straps resampled at every transaction start
// - configuration write restarts running conversion
`timescale 1ns/1ps
module aici_core import aici_pkg::*; #(
    parameter int RAW_W = 25,
    parameter int TIMEOUT_CYCLES = TIMEOUT_MOD_PERIODS * MOD_PERIOD_CYC,
    parameter logic [6:0] DEVICE_ID = 7'h00 // arbitrary value
) (
    // system clock and reset
    input wire logic CLK_I,
    input wire logic RESET_I,
    // serial bus, sda is open drain
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    // address straps
    input wire logic ADDR_STRAP_LOW_I,
    input wire logic ADDR_STRAP_HIGH_I,
    // open-drain conversion ready pin
    output logic CONVERSION_READY_N_O,
    output logic CONVERSION_READY_N_OE_O,
    // converter side
    input wire logic RESULT_VALID_I,
    input wire logic [RAW_W-1:0] RESULT_RAW_I,
    output logic CONV_RESTART_O,
    output logic ANALOG_ON_O,
    output logic [7:0] CONFIG_O,
    output logic BUS_BUSY_O
);
    localparam int TMO_W = $clog2(TIMEOUT_CYCLES + 1);
    localparam int REL_W = $clog2(READY_RELEASE_CYC + 1);
    localparam int FREE_W = $clog2(BUS_FREE_CYC + 1);

    // refuse widths the saturation and timeout logic cannot serve
    if (RAW_W < 24) begin : g_chk_raw
        $error("RAW_W must be at least 24");
    end
    if (TIMEOUT_CYCLES < 2) begin : g_chk_tmo
        $error("TIMEOUT_CYCLES must be at least 2");
    end

    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_p;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        logic strap_lo_m;
        logic strap_lo_s;
        logic strap_hi_m;
        logic strap_hi_s;
        logic [1:0] strap_idle;
        logic [1:0] strap_start;
        logic [1:0] strap_low;
        aici_state_e st;
        logic lead;
        logic [2:0] bitcnt;
        logic is_read;
        logic gc;
        logic cfgwr_pend;
        logic mnack;
        logic sda_oe;
        logic [23:0] tx;
        logic [TMO_W-1:0] tmo;
        logic busy;
        logic [FREE_W-1:0] free;
        logic [7:0] cfg;
        logic [23:0] result;
        logic fresh;
        logic [REL_W-1:0] rel;
        logic ready_oe;
        logic conv_active;
        logic sleep_pend;
        logic analog_on;
        logic restart;
    } aici_reg_s;

    aici_reg_s q;
    aici_reg_s d;
    logic [7:0] link_shift_q;
    logic [7:0] rx;
    logic [6:0] own_addr;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic addr_end;
    logic addr_hit;
    logic gc_hit;
    logic wr_end;
    logic cmd_latch;
    logic cfg_write;
    logic soft_rst;
    logic tmo_hit;
    logic cont_mode;

    function automatic logic [1:0] strap_code(input logic idle, input logic start, input logic low);
        if (!idle) begin
            return STRAP_GND;
        end else if (!start) begin
            return STRAP_SDA;
        end else if (low) begin
            return STRAP_VDD;
        end
        return STRAP_SCL;
    endfunction

    function automatic logic cmd_is(input logic [7:0] b, input logic [7:0] val, input logic [7:0] mask);
        return (b & mask) == val;
    endfunction

    // clip over-range codes instead of letting the upper bits wrap
    function automatic logic [23:0] saturate(input logic [RAW_W-1:0] raw);
        logic [RAW_W-24:0] top;
        top = raw[RAW_W-1:23];
        if (top == {(RAW_W - 23){raw[RAW_W-1]}}) begin
            return raw[23:0];
        end else if (raw[RAW_W-1]) begin
            return SAT_NEG;
        end
        return SAT_POS;
    endfunction

    // link domain: only the receive shifter runs on the bus clock; it is read by the
    // system side after the synchronised falling edge, while the master holds it still
    always_ff @(posedge SCL_I) begin
        link_shift_q <= {link_shift_q[6:0], SDA_I};
    end

    // bus events from the synchronised pins; the first stage feeds only the second
    assign scl_rise = q.scl_s & ~q.scl_p;
    assign scl_fall = ~q.scl_s & q.scl_p;
    assign start_det = q.scl_s & q.scl_p & ~q.sda_s & q.sda_p;
    assign stop_det = q.scl_s & q.scl_p & q.sda_s & ~q.sda_p;
    assign rx = link_shift_q;
    assign own_addr = {ADDR_PREFIX, strap_code(q.strap_idle[1], q.strap_start[1], q.strap_low[1]),
                       strap_code(q.strap_idle[0], q.strap_start[0], q.strap_low[0])};
    assign addr_end = (q.st == ST_ADDR) && scl_fall && !q.lead && (q.bitcnt == 3'h7);
    assign addr_hit = (rx[7:1] == own_addr);
    assign gc_hit = (rx[7:1] == GCALL_ADDR) && !rx[0];
    assign wr_end = (q.st == ST_WR) && scl_fall && (q.bitcnt == 3'h7);
    assign cmd_latch = wr_end && !q.gc && !q.cfgwr_pend;
    assign cfg_write = wr_end && !q.gc && q.cfgwr_pend;
    assign soft_rst = (cmd_latch && cmd_is(rx, CMD_RESET_VAL, CMD_RESET_MASK))
                      || (wr_end && q.gc && (rx == GCALL_RESET));
    assign tmo_hit = (q.st != ST_IDLE) && (q.tmo == TMO_W'(TIMEOUT_CYCLES - 1));
    assign cont_mode = q.cfg[CFG_CONT_BIT];

    // next state of the whole block except the receive shifter
    always_comb begin
        d = q;
        d.restart = 1'b0;
        d.scl_m = SCL_I;
        d.scl_s = q.scl_m;
        d.scl_p = q.scl_s;
        d.sda_m = SDA_I;
        d.sda_s = q.sda_m;
        d.sda_p = q.sda_s;
        d.strap_lo_m = ADDR_STRAP_LOW_I;
        d.strap_lo_s = q.strap_lo_m;
        d.strap_hi_m = ADDR_STRAP_HIGH_I;
        d.strap_hi_s = q.strap_hi_m;
        // straps tied to sda or scl are told apart by the bus level they follow
        if (q.scl_s && q.sda_s) begin
            d.strap_idle = {q.strap_hi_s, q.strap_lo_s};
        end
        // idle timer restarts on every clock edge of the bus
        if (q.st == ST_IDLE || scl_rise || scl_fall) begin
            d.tmo = '0;
        end else begin
            d.tmo = q.tmo + 1'b1;
        end
        // bus-free time counts down after a stop
        if (q.free != '0) begin
            d.free = q.free - 1'b1;
        end
        if (start_det) begin
            d.st = ST_ADDR;
            d.busy = 1'b1;
            d.free = '0;
            d.lead = 1'b1;
            d.bitcnt = 3'h0;
            d.sda_oe = 1'b0;
            d.gc = 1'b0;
            d.cfgwr_pend = 1'b0;
            d.strap_start = {q.strap_hi_s, q.strap_lo_s};
        end else if (stop_det) begin
            d.st = ST_IDLE;
            d.busy = 1'b0;
            d.free = FREE_W'(BUS_FREE_CYC);
            d.sda_oe = 1'b0;
        end else if (tmo_hit) begin
            d.st = ST_IDLE;
            d.sda_oe = 1'b0;
            d.cfgwr_pend = 1'b0;
        end else begin
            case (q.st)
                ST_ADDR: begin
                    if (scl_fall && q.lead) begin
                        d.lead = 1'b0;
                        d.strap_low = {q.strap_hi_s, q.strap_lo_s};
                    end else if (scl_fall) begin
                        d.bitcnt = q.bitcnt + 3'h1;
                        if (q.bitcnt == 3'h7) begin
                            if (addr_hit || gc_hit) begin
                                d.st = ST_ADDR_ACK;
                                d.sda_oe = 1'b1;
                                d.is_read = rx[0] && !gc_hit;
                                d.gc = gc_hit;
                            end else begin
                                d.st = ST_SKIP;
                            end
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        d.bitcnt = 3'h0;
                        if (q.is_read) begin
                            d.st = ST_RD;
                            d.sda_oe = ~q.tx[23];
                        end else begin
                            d.st = ST_WR;
                            d.sda_oe = 1'b0;
                        end
                    end
                end
                ST_WR: begin
                    if (scl_fall) begin
                        d.bitcnt = q.bitcnt + 3'h1;
                        if (q.bitcnt == 3'h7) begin
                            d.st = ST_WR_ACK;
                            d.sda_oe = 1'b1;
                        end
                    end
                end
                ST_WR_ACK: begin
                    if (scl_fall) begin
                        d.st = ST_WR;
                        d.sda_oe = 1'b0;
                        d.bitcnt = 3'h0;
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        d.bitcnt = q.bitcnt + 3'h1;
                        d.tx = {q.tx[22:0], 1'b0};
                        if (q.bitcnt == 3'h7) begin
                            d.st = ST_RD_ACK;
                            d.sda_oe = 1'b0;
                        end else begin
                            d.sda_oe = ~q.tx[22];
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        d.mnack = q.sda_s;
                    end
                    if (scl_fall) begin
                        d.bitcnt = 3'h0;
                        if (q.mnack) begin
                            d.st = ST_SKIP;
                        end else begin
                            d.st = ST_RD;
                            d.sda_oe = ~q.tx[23];
                        end
                    end
                end
                default: begin
                    d.sda_oe = 1'b0;
                end
            endcase
        end
        // command execution at the latch edge; a general call covers one byte only, later bytes decode as commands
        if (wr_end && q.gc) begin
            d.gc = 1'b0;
        end
        if (cfg_write) begin
            d.cfg = rx;
            d.cfgwr_pend = 1'b0;
            d.restart = q.conv_active;
        end
        if (soft_rst) begin
            d.cfg = CFG_RESET;
            d.conv_active = 1'b0;
            d.analog_on = 1'b0;
            d.sleep_pend = 1'b0;
            d.fresh = 1'b0;
            d.rel = '0;
            d.tx = '0;
        end else if (cmd_latch) begin
            if (cmd_is(rx, CMD_START_VAL, CMD_START_MASK)) begin
                d.restart = 1'b1;
                d.conv_active = 1'b1;
                d.analog_on = 1'b1;
                d.sleep_pend = 1'b0;
            end else if (cmd_is(rx, CMD_SLEEP_VAL, CMD_SLEEP_MASK)) begin
                d.sleep_pend = q.conv_active;
                d.analog_on = q.conv_active;
            end else if (cmd_is(rx, CMD_FETCH_VAL, CMD_FETCH_MASK)) begin
                d.tx = q.result;
                d.fresh = 1'b0;
                d.rel = '0;
            end else if (cmd_is(rx, CMD_REGRD_VAL, CMD_REGRD_MASK)) begin
                d.tx = rx[REGRD_SEL_BIT] ? {q.fresh, DEVICE_ID, 16'h0000} : {q.cfg, 16'h0000};
            end else if (cmd_is(rx, CMD_REGWR_VAL, CMD_REGWR_MASK)) begin
                d.cfgwr_pend = 1'b1;
            end
            // any other byte is acknowledged and otherwise ignored
        end
        // a result arriving with the fetch latch wins over the clear; it keeps the pin low except in continuous mode, where an unread fetched result opens the release gap
        if (q.rel != '0) begin
            d.rel = q.rel - 1'b1;
        end
        if (RESULT_VALID_I) begin
            d.result = saturate(RESULT_RAW_I);
            d.fresh = 1'b1;
            if (q.fresh && cont_mode) begin
                d.rel = REL_W'(READY_RELEASE_CYC);
            end
            if ((!cont_mode || q.sleep_pend) && !d.restart) begin
                d.conv_active = 1'b0;
                d.analog_on = 1'b0;
                d.sleep_pend = 1'b0;
            end
        end
        d.ready_oe = d.fresh && (d.rel == '0);
    end

    // one register for the whole state on the system clock
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            q <= '0;
            q.scl_m <= 1'b1;
            q.scl_s <= 1'b1;
            q.scl_p <= 1'b1;
            q.sda_m <= 1'b1;
            q.sda_s <= 1'b1;
            q.sda_p <= 1'b1;
            q.st <= ST_IDLE;
            q.cfg <= CFG_RESET;
        end else begin
            q <= d;
        end
    end

    // open-drain pins only ever pull low
    assign SDA_O = 1'b0;
    assign SDA_OE_O = q.sda_oe;
    assign CONVERSION_READY_N_O = 1'b0;
    assign CONVERSION_READY_N_OE_O = q.ready_oe;
    assign CONV_RESTART_O = q.restart;
    assign ANALOG_ON_O = q.analog_on;
    assign CONFIG_O = q.cfg;
    assign BUS_BUSY_O = q.busy || (q.free != '0);

    // checks on the system clock
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);

    AST_FETCH_RELEASE: assert property (
        cmd_latch && cmd_is(rx, CMD_FETCH_VAL, CMD_FETCH_MASK) && !RESULT_VALID_I |=> !CONVERSION_READY_N_OE_O)
        else $error("ready pin not released after fetch");
    AST_NEW_LOW: assert property (
        RESULT_VALID_I && !q.fresh |=> CONVERSION_READY_N_OE_O)
        else $error("ready pin not pulled low on new result");
    AST_REPLACE_GAP: assert property (
        RESULT_VALID_I && q.fresh && cont_mode && !soft_rst |=> !CONVERSION_READY_N_OE_O ##1 !CONVERSION_READY_N_OE_O)
        else $error("ready pin not released before newer result");
    AST_START_ADDR: assert property (
        start_det |=> (q.st == ST_ADDR) && BUS_BUSY_O && !SDA_OE_O)
        else $error("start condition not taken");
    AST_ADDR_ACK: assert property (
        addr_end && !start_det && !stop_det && !tmo_hit && addr_hit |=> SDA_OE_O && (q.st == ST_ADDR_ACK))
        else $error("own address not acknowledged");
    AST_ADDR_NACK: assert property (
        addr_end && !addr_hit && !gc_hit |=> !SDA_OE_O)
        else $error("foreign address acknowledged");
    AST_GCALL_RESET: assert property (
        wr_end && q.gc && (rx == GCALL_RESET) |=> (CONFIG_O == CFG_RESET) && !ANALOG_ON_O)
        else $error("general call reset had no effect");
    AST_TIMEOUT: assert property (
        tmo_hit && !start_det && !stop_det |=> (q.st == ST_IDLE) && !SDA_OE_O)
        else $error("timeout did not reset the interface");
    AST_SAT_POS: assert property (
        RESULT_VALID_I && !RESULT_RAW_I[RAW_W-1] && (RESULT_RAW_I[RAW_W-2:0] > SAT_POS) |=> q.result == SAT_POS)
        else $error("positive result not clipped");
    AST_START_CMD: assert property (
        cmd_latch && cmd_is(rx, CMD_START_VAL, CMD_START_MASK) |=> CONV_RESTART_O && ANALOG_ON_O ##1 !CONV_RESTART_O)
        else $error("start command did not restart conversion");
    AST_SLEEP_WAIT: assert property (
        cmd_latch && cmd_is(rx, CMD_SLEEP_VAL, CMD_SLEEP_MASK) && q.conv_active && !RESULT_VALID_I |=> ANALOG_ON_O)
        else $error("sleep did not wait for the running conversion");
    AST_CFG_RESTART: assert property (
        cfg_write && q.conv_active |=> CONV_RESTART_O && (CONFIG_O == $past(rx)))
        else $error("configuration write did not restart conversion");
endmodule

// ===== tb/aici_master.sv
// bus master model for the serial command interface, running on its own link clock
`timescale 1ns/1ps
module aici_master (
    // device pull on the shared data wire
    input wire logic dev_oe_i,
    // resolved bus lines
    output logic scl_o,
    output logic sda_o
);
    logic tck = 1'b0;
    logic m_oe = 1'b0;
    // link clock, phase unrelated to the system clock
    initial begin
        #7;
        forever #32 tck = ~tck;
    end
    // pull-up wire: low while either party pulls, high once both release
    assign sda_o = ~(m_oe | dev_oe_i);
    // clock line rests high outside frames
    initial scl_o = 1'b1;
    task automatic tk(input int n);
        repeat (n) @(posedge tck);
        #1;
    endtask
    // data changes only while scl is low, sampled mid-high
    task automatic bitx(input logic b, output logic r);
        tk(3);
        m_oe = ~b;
        tk(5);
        scl_o = 1'b1;
        tk(4);
        r = sda_o;
        tk(4);
        scl_o = 1'b0;
    endtask
    // start or repeated start: sda falls with scl high
    task automatic start();
        tk(3);
        m_oe = 1'b0;
        tk(5);
        scl_o = 1'b1;
        tk(8);
        m_oe = 1'b1;
        tk(8);
        scl_o = 1'b0;
    endtask
    // stop: sda rises with scl high, then bus-free wait
    task automatic stop();
        tk(3);
        m_oe = 1'b1;
        tk(5);
        scl_o = 1'b1;
        tk(8);
        m_oe = 1'b0;
        tk(8);
    endtask
    // byte out msb first, ninth bit released for the answer
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
        end
        bitx(1'b1, r);
        ack = ~r;
    endtask
    // byte in; every byte acknowledged except the last
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(last, r);
    endtask
endmodule

// ===== tb/adc_i2c_command_interface_tb_top.sv
// self-checking bench for the serial command interface
`timescale 1ns/1ps
module adc_i2c_command_interface_tb_top;
    import aici_pkg::*;
    localparam logic [6:0] ME = 7'h40;
    logic CLK_I = 1'b0;
    logic RESET_I = 1'b1;
    logic s_lo = 1'b0;
    logic s_hi = 1'b0;
    logic valid = 1'b0;
    logic [24:0] raw = 25'h0;
    logic scl, sda, sda_oe, rdy_oe, restart, analog, busy;
    logic [7:0] cfg;
    logic [23:0] v;
    logic ack;
    int miscompares = 0;
    int tests_run = 0;
    int restarts = 0;
    aici_core #(.TIMEOUT_CYCLES(200)) dut (.CLK_I(CLK_I), .RESET_I(RESET_I), .SCL_I(scl), .SDA_I(sda),
        .SDA_O(), .SDA_OE_O(sda_oe), .ADDR_STRAP_LOW_I(s_lo), .ADDR_STRAP_HIGH_I(s_hi),
        .CONVERSION_READY_N_O(), .CONVERSION_READY_N_OE_O(rdy_oe), .RESULT_VALID_I(valid),
        .RESULT_RAW_I(raw), .CONV_RESTART_O(restart), .ANALOG_ON_O(analog), .CONFIG_O(cfg), .BUS_BUSY_O(busy));
    aici_master host (.dev_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
    // system clock, 25 MHz
    initial begin
        forever #20 CLK_I = ~CLK_I;
    end
    // restart pulses are one cycle wide, so count them as they pass
    always @(posedge CLK_I) begin
        if (restart === 1'b1) begin
            restarts++;
        end
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_I);
        #1;
    endtask
    task automatic pulse(input logic [24:0] r);
        cyc(1);
        raw = r;
        valid = 1'b1;
        cyc(1);
        valid = 1'b0;
    endtask
    // write frame of n bytes, each acknowledged
    task automatic wr(input logic [6:0] a, input logic [15:0] d, input int n);
        host.start();
        host.wbyte({a, 1'b0}, ack);
        chk(24'(ack), 24'h1);
        for (int i = 0; i < n; i++) begin
            host.wbyte(d[15-8*i -: 8], ack);
            chk(24'(ack), 24'h1);
        end
        host.stop();
    endtask
    // command frame, repeated start, read frame of three bytes
    task automatic rd(input logic [7:0] c);
        logic [7:0] b0, b1, b2;
        host.start();
        host.wbyte({ME, 1'b0}, ack);
        host.wbyte(c, ack);
        host.start();
        host.wbyte({ME, 1'b1}, ack);
        chk(24'(ack), 24'h1);
        host.rbyte(1'b0, b0);
        host.rbyte(1'b0, b1);
        host.rbyte(1'b1, b2);
        host.stop();
        v = {b0, b1, b2};
    endtask
    task automatic t_addr();
        host.start();
        chk(24'(busy), 24'h1);
        host.wbyte({7'h41, 1'b0}, ack);
        chk(24'(ack), 24'h0);
        host.stop();
        chk(24'(busy), 24'h1);
        cyc(10);
        chk(24'(busy), 24'h0);
        s_lo = 1'b1;
        wr(7'h41, 16'hff00, 1);
        cyc(1);
        s_hi = 1'b1;
        wr(7'h45, 16'h0000, 1);
        cyc(1);
        s_lo = 1'b0;
        s_hi = 1'b0;
        $display("address test done");
    endtask
    task automatic t_result();
        logic [24:0] rin [4] = '{25'h0ffffff, 25'h1000000, 25'h1fffffe, 25'h0000123};
        logic [23:0] rex [4] = '{SAT_POS, SAT_NEG, 24'hfffffe, 24'h000123};
        for (int i = 0; i < 4; i++) begin
            pulse(rin[i]);
            cyc(2);
            chk(24'(rdy_oe), 24'h1);
            rd(8'h1f);
            chk(v, rex[i]);
            chk(24'(rdy_oe), 24'h0);
        end
        $display("result test done");
    endtask
    task automatic t_cmds();
        int r0;
        for (int i = 0; i < 2; i++) begin
            r0 = restarts;
            wr(ME, {8'h08 | 8'(i), 8'h00}, 1);
            chk(24'(restarts - r0), 24'h1);
            chk(24'(analog), 24'h1);
        end
        wr(ME, 16'h0300, 1);
        chk(24'(analog), 24'h1);
        pulse(25'h0000005);
        cyc(3);
        chk(24'(analog), 24'h0);
        r0 = restarts;
        wr(ME, 16'h4102, 2);
        chk(24'({cfg, 8'(restarts - r0)}), 24'h000200);
        wr(ME, 16'h0800, 1);
        r0 = restarts;
        wr(ME, 16'h4302, 2);
        chk(24'(restarts - r0), 24'h1);
        rd(8'h23);
        chk(v, 24'h020000);
        $display("command test done");
    endtask
    task automatic t_cont();
        // collect the result left unread so the next one starts without a release gap
        rd(8'h1f);
        chk(v, 24'h000005);
        pulse(25'h0000011);
        cyc(2);
        chk(24'(rdy_oe), 24'h1);
        pulse(25'h0000022);
        cyc(3);
        chk(24'(rdy_oe), 24'h0);
        cyc(55);
        chk(24'(rdy_oe), 24'h1);
        $display("continuous test done");
    endtask
    task automatic t_resets();
        wr(ME, 16'h0700, 1);
        chk({cfg, 7'h0, analog}, 16'h0);
        wr(ME, 16'h4102, 2);
        wr(7'h00, 16'h0600, 1);
        chk(24'(cfg), 24'h0);
        $display("reset test done");
    endtask
    task automatic t_timeout();
        pulse(25'h0000123);
        host.start();
        host.wbyte({ME, 1'b0}, ack);
        host.wbyte(8'h10, ack);
        host.start();
        host.wbyte({ME, 1'b1}, ack);
        cyc(8);
        chk(24'(sda_oe), 24'h1);
        cyc(250);
        chk(24'(sda_oe), 24'h0);
        host.stop();
        rd(8'h10);
        chk(v, 24'h000123);
        $display("timeout test done");
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // watchdog, well beyond the expected 0.75 ms of traffic
    initial begin
        #4000000;
        miscompares++;
        finish_test();
    end
    // main sequence
    initial begin
        cyc(20);
        RESET_I = 1'b0;
        cyc(5);
        chk({cfg, 4'h0, analog, rdy_oe, busy, sda_oe}, 24'h0);
        t_addr();
        t_result();
        t_cmds();
        t_cont();
        t_resets();
        t_timeout();
        finish_test();
    end
endmodule
